// ==== logic/sdi_pkg.sv ====
// Package with constants and types of the station diagnostic indicator
package sdi_pkg;
    localparam int unsigned NUM_SLOTS = 17;
    localparam logic [1:0] MS_FAULT = 2'b01;
    localparam logic [1:0] MS_NO_MODULE = 2'b11;
    localparam logic [1:0] MS_OK = 2'b00;
    localparam int unsigned PROC_IRQ_LEN = 4;
    localparam int unsigned DIAG_REC_LEN = 44;
    localparam int unsigned HW_IRQ_LEN = 4;
    localparam int unsigned IRQ_SECT_MAX = 48;
    localparam logic [7:0] PROC_PAD_BYTE = 8'h00;
    // Flash half period: 0.5 s at 250 MHz
    localparam int unsigned CLK_MHZ = 250;
    localparam int unsigned FLASH_MS = 500;
    localparam int unsigned FLASH_CYC = FLASH_MS * 1000 * CLK_MHZ;
    localparam int unsigned FLASH_W = 27;
    localparam logic [FLASH_W-1:0] FLASH_RST = 27'h0;
    // Register offsets
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h1;
    localparam logic [3:0] REG_IRQ_STAT = 4'h2;
    localparam logic [3:0] REG_IRQ_MASK = 4'h3;
    localparam logic [3:0] REG_SLOT_ID = 4'h4;
    localparam logic [3:0] REG_SLOT_MS = 4'h5;
    localparam logic [3:0] REG_IRQ_INFO = 4'h6;
    localparam logic [31:0] CTRL_RST = 32'h0;
    localparam logic [31:0] MASK_RST = 32'h0;
    localparam logic [31:0] UNMAPPED_DATA = 32'h0;
    // Interrupt status bits
    localparam int unsigned EV_FAIL = 0;
    localparam int unsigned EV_CFG = 1;
    localparam int unsigned EV_MAINTENANCE_INDICATOR = 2;
    localparam int unsigned EV_DIAG = 3;
    localparam int unsigned EV_W = 4;
    typedef enum logic [1:0] {
        SDI_IRQ_NONE = 2'b00,
        SDI_IRQ_DIAG = 2'b01,
        SDI_IRQ_HW = 2'b10
    } sdi_irq_kind_t;
    typedef enum logic [1:0] {
        SDI_RUN = 2'b00,
        SDI_FAILED = 2'b01
    } sdi_state_t;
endpackage

// ==== logic/sdi_station.sv ====
// Station diagnostics, slave failure and indicator logic
//
// Overview of operation
// - Process interrupt bytes three and four of the digital input status read zero.
// - Missing end module, too many modules, bad backplane always fail the station.
// - Faulty configuration sets identifier diagnostic bits of slots one to seventeen.
// - Slots before the failing slot report status code 01.
// - Failing slot and every later slot report status code 11.
// - Cyclic input and output data stop while the slave has failed.
// - Master events or slave expansion errors enter the slave failure.
// - Diagnostics, module events and record requests continue during failure.
// - Error-free exchange with supply shows group off, bus off, supply on.
// - Outside firmware update, missing supply or defective hardware turns all three indicators off.
// - Wrong or missing connect frame flashes bus fault, supply on.
// - No controller or no bus communication holds bus fault on.
// - Config mismatch, module error or pending diagnostics light group error.
// - Firmware update lights group and bus fault, supply off.
// - Maintenance requirement or request lights the maintenance indicator.
// - Each maintenance condition also raises an alarm to the controller.
// - Interrupt section length never exceeds 48 bytes.
// - Diagnostic interrupt carries 44 record bytes at offset four; hardware carries 4.
`timescale 1ns/1ps
`default_nettype none
module sdi_station
    import sdi_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Station conditions
    input wire logic end_module_missing,
    input wire logic too_many_modules,
    input wire logic backplane_fault,
    input wire logic [4:0] fail_slot,
    input wire logic master_fail_event,
    input wire logic supply_ok,
    input wire logic hw_defect,
    input wire logic connect_frame_bad,
    input wire logic no_controller,
    input wire logic cfg_mismatch,
    input wire logic module_error,
    input wire logic diag_pending,
    input wire logic fw_update,
    input wire logic maintenance_indicator_request,
    // Cyclic user data
    input wire logic [31:0] cyc_out_in,
    output logic [31:0] cyc_out_data,
    input wire logic [31:0] cyc_in_in,
    output logic [31:0] cyc_in_data,
    output logic data_exchange,
    // Diagnostic and record service
    input wire logic module_event,
    input wire logic record_req,
    output logic record_ack,
    output logic maintenance_indicator_alarm,
    // Indicators and interrupt
    output logic group_error_indicator,
    output logic bus_fault_indicator,
    output logic supply_indicator,
    output logic maintenance_indicator,
    output logic irq
);
    import sdi_pkg::*;

    function automatic logic [1:0] slot_code(input logic [4:0] slot,
        input logic [4:0] bad, input logic faulty);
        if (!faulty)
            slot_code = MS_OK;
        else if (slot < bad)
            slot_code = MS_FAULT;
        else
            slot_code = MS_NO_MODULE;
    endfunction

    sdi_state_t state_q, state_d;
    logic [31:0] ctrl_q;
    logic [EV_W-1:0] irq_stat_q, irq_stat_d, irq_mask_q;
    logic [FLASH_W-1:0] flash_cnt_q;
    logic flash_q;
    logic maintenance_indicator_q, cfg_q;
    logic [31:0] cyc_out_q, cyc_in_q;
    logic data_exchange_q, record_ack_q, maintenance_indicator_alarm_q;
    logic ge_q, bf_q, on_q, mt_q;
    logic [31:0] rdata_q;
    logic rvalid_q;
    logic [33:0] slot_ms;
    logic [16:0] slot_id;
    sdi_irq_kind_t irq_kind;

    wire cfg_faulty = end_module_missing | too_many_modules
        | backplane_fault;
    wire fail_entry = cfg_faulty | master_fail_event;
    wire sw_release = ctrl_q[0];
    wire acc = avs_read | avs_write;
    wire wr_ctrl = avs_write & rvalid_q & (avs_address == REG_CTRL);
    wire wr_clr = avs_write & rvalid_q & (avs_address == REG_IRQ_STAT);
    wire wr_mask = avs_write & rvalid_q & (avs_address == REG_IRQ_MASK);
    wire maintenance_indicator_rise = maintenance_indicator_request & ~maintenance_indicator_q;
    wire cfg_rise = cfg_faulty & ~cfg_q;
    wire [EV_W-1:0] ev = {diag_pending, maintenance_indicator_rise, cfg_rise,
        fail_entry & (state_q == SDI_RUN)};
    wire no_power = ~supply_ok | hw_defect;
    wire [7:0] irq_len = (irq_kind == SDI_IRQ_DIAG) ?
        8'(DIAG_REC_LEN + 4) : (irq_kind == SDI_IRQ_HW) ?
        8'(HW_IRQ_LEN + 4) : 8'h0;
    wire [7:0] irq_len_lim = (irq_len > 8'(IRQ_SECT_MAX)) ?
        8'(IRQ_SECT_MAX) : irq_len;
    wire [31:0] proc_status = {PROC_PAD_BYTE, PROC_PAD_BYTE,
        cyc_in_q[15:0]};

    genvar g;
    generate
        for (g = 0; g < NUM_SLOTS; g = g + 1)
        begin : g_slot
            assign slot_id[g] = cfg_faulty;
            assign slot_ms[2*g +: 2] = slot_code(5'(g + 1), fail_slot,
                cfg_faulty);
        end
    endgenerate

    assign irq_kind = diag_pending ? SDI_IRQ_DIAG :
        (module_event ? SDI_IRQ_HW : SDI_IRQ_NONE);

    // Failure state machine
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            SDI_RUN:
            begin
                if (fail_entry)
                    state_d = SDI_FAILED;
            end
            SDI_FAILED:
            begin
                if (!fail_entry && sw_release)
                    state_d = SDI_RUN;
            end
            default:
                state_d = SDI_FAILED;
        endcase
    end

    assign irq_stat_d = (irq_stat_q & ~(wr_clr ? avs_writedata[EV_W-1:0]
        : {EV_W{1'b0}})) | ev;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_q <= SDI_FAILED;
            ctrl_q <= CTRL_RST;
            irq_stat_q <= '0;
            irq_mask_q <= MASK_RST[EV_W-1:0];
            maintenance_indicator_q <= 1'b0;
            cfg_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            if (wr_ctrl && avs_byteenable[0])
                ctrl_q <= avs_writedata;
            irq_stat_q <= irq_stat_d;
            if (wr_mask && avs_byteenable[0])
                irq_mask_q <= avs_writedata[EV_W-1:0];
            maintenance_indicator_q <= maintenance_indicator_request;
            cfg_q <= cfg_faulty;
        end
    end

    // Cyclic data gated by failure
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            cyc_out_q <= '0;
            cyc_in_q <= '0;
            data_exchange_q <= 1'b0;
        end
        else
        begin
            data_exchange_q <= (state_d == SDI_RUN);
            if (state_d == SDI_RUN)
            begin
                cyc_out_q <= cyc_out_in;
                cyc_in_q <= cyc_in_in;
            end
        end
    end

    // Records and alarms served in every state
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            record_ack_q <= 1'b0;
            maintenance_indicator_alarm_q <= 1'b0;
        end
        else
        begin
            record_ack_q <= record_req;
            maintenance_indicator_alarm_q <= maintenance_indicator_rise;
        end
    end

    // Flash timer
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            flash_cnt_q <= FLASH_RST;
            flash_q <= 1'b0;
        end
        else if (flash_cnt_q == FLASH_W'(FLASH_CYC - 1))
        begin
            flash_cnt_q <= FLASH_RST;
            flash_q <= ~flash_q;
        end
        else
            flash_cnt_q <= flash_cnt_q + 1'b1;
    end

    // Indicator priority
    logic ge_d, bf_d, on_d;
    always_comb
    begin
        ge_d = cfg_mismatch | module_error | diag_pending
            | cfg_faulty;
        bf_d = 1'b0;
        on_d = 1'b1;
        if (no_controller)
            bf_d = 1'b1;
        else if (connect_frame_bad)
            bf_d = flash_q;
        if (fw_update)
        begin
            ge_d = 1'b1;
            bf_d = 1'b1;
            on_d = 1'b0;
        end
        else if (no_power)
        begin
            ge_d = 1'b0;
            bf_d = 1'b0;
            on_d = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            ge_q <= 1'b0;
            bf_q <= 1'b0;
            on_q <= 1'b0;
            mt_q <= 1'b0;
        end
        else
        begin
            ge_q <= ge_d;
            bf_q <= bf_d;
            on_q <= on_d;
            mt_q <= maintenance_indicator_request;
        end
    end

    // Register read
    wire [31:0] rd_mux =
        (avs_address == REG_CTRL) ? ctrl_q :
        (avs_address == REG_STATUS) ? {26'h0, cfg_faulty, no_power,
            fw_update, maintenance_indicator_request, state_q} :
        (avs_address == REG_IRQ_STAT) ? {28'h0, irq_stat_q} :
        (avs_address == REG_IRQ_MASK) ? {28'h0, irq_mask_q} :
        (avs_address == REG_SLOT_ID) ? {15'h0, slot_id} :
        (avs_address == REG_SLOT_MS) ? slot_ms[31:0] :
        (avs_address == REG_IRQ_INFO) ? {6'h0, slot_ms[33:32],
            6'h0, irq_kind, irq_len_lim, proc_status[31:24]} :
        UNMAPPED_DATA;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            rdata_q <= '0;
            rvalid_q <= 1'b0;
        end
        else
        begin
            rvalid_q <= acc & ~rvalid_q;
            if (avs_read)
                rdata_q <= rd_mux;
        end
    end

    assign avs_waitrequest = acc & ~rvalid_q;
    assign avs_readdata = rdata_q;
    assign cyc_out_data = cyc_out_q;
    assign cyc_in_data = proc_status | {16'h0, cyc_in_q[15:0]};
    assign data_exchange = data_exchange_q;
    assign record_ack = record_ack_q;
    assign maintenance_indicator_alarm = maintenance_indicator_alarm_q;
    assign group_error_indicator = ge_q;
    assign bus_fault_indicator = bf_q;
    assign supply_indicator = on_q;
    assign maintenance_indicator = mt_q;
    assign irq = |(irq_stat_q & irq_mask_q);
endmodule
`default_nettype wire

// ==== verif/sdi_master_model.sv ====
// Far-side master model: link conditions and output user data
`timescale 1ns/1ps
`default_nettype none
module sdi_master_model
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Bench commands
    input wire logic [2:0] cmd,
    input wire logic [31:0] word,
    // Toward the station
    output logic master_fail_event,
    output logic no_controller,
    output logic connect_frame_bad,
    output logic [31:0] cyc_out_in
);
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            {master_fail_event, no_controller, connect_frame_bad} <= 3'h0;
            cyc_out_in <= 32'h0;
        end
        else
        begin
            {master_fail_event, no_controller, connect_frame_bad} <= cmd;
            cyc_out_in <= word;
        end
    end
endmodule
`default_nettype wire

// ==== verif/sdi_station_sva.sv ====
// Assertions on the station diagnostic indicator ports
`timescale 1ns/1ps
`default_nettype none
module sdi_station_sva
(
    // Watched signals
    input wire logic clk, reset, end_module_missing, too_many_modules,
    input wire logic backplane_fault, master_fail_event, supply_ok,
    input wire logic hw_defect, connect_frame_bad, no_controller,
    input wire logic cfg_mismatch, module_error, diag_pending, fw_update,
    input wire logic maintenance_indicator_request, record_req, record_ack, maintenance_indicator_alarm,
    input wire logic data_exchange, group_error_indicator,
    input wire logic bus_fault_indicator, supply_indicator,
    input wire logic maintenance_indicator,
    input wire logic [31:0] cyc_out_data, cyc_in_data
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    wire pwr = supply_ok & !hw_defect & !fw_update;
    wire fc = end_module_missing | too_many_modules | backplane_fault;
    wire grp = cfg_mismatch | module_error | diag_pending;
    a_fw_pattern: assert property (fw_update |=> group_error_indicator
        && bus_fault_indicator && !supply_indicator) else $error("fw");
    a_power_off: assert property (!fw_update && (!supply_ok || hw_defect)
        |=> !group_error_indicator && !bus_fault_indicator && !supply_indicator)
        else $error("power off");
    a_no_ctrl: assert property (pwr && no_controller && !connect_frame_bad
        |=> bus_fault_indicator && supply_indicator) else $error("no ctrl");
    a_group_err: assert property (pwr && grp |=> group_error_indicator
        && supply_indicator) else $error("group");
    a_clean_run: assert property (pwr && data_exchange && !fc && !grp
        && !connect_frame_bad && !no_controller |=> !group_error_indicator
        && !bus_fault_indicator && supply_indicator) else $error("clean");
    a_frame_on: assert property (pwr && connect_frame_bad
        |=> supply_indicator) else $error("frame");
    a_maintenance_indicator_led: assert property (1'b1 |=>
        maintenance_indicator == $past(maintenance_indicator_request)) else $error("maintenance_indicator");
    a_maintenance_indicator_alarm: assert property ($rose(maintenance_indicator_request)
        |=> maintenance_indicator_alarm ##1 !maintenance_indicator_alarm) else $error("alarm");
    a_record_ack: assert property (record_req |=> record_ack)
        else $error("record");
    a_fail_stop: assert property (master_fail_event || fc
        |-> ##[1:3] !data_exchange) else $error("fail");
    a_data_hold: assert property (!data_exchange [*2] |->
        $stable(cyc_out_data) && $stable(cyc_in_data)) else $error("hold");
endmodule
bind sdi_station sdi_station_sva u_sva (.clk, .reset, .end_module_missing,
    .too_many_modules, .backplane_fault, .master_fail_event, .supply_ok,
    .hw_defect, .connect_frame_bad, .no_controller, .cfg_mismatch,
    .module_error, .diag_pending, .fw_update, .maintenance_indicator_request, .record_req,
    .record_ack, .maintenance_indicator_alarm, .data_exchange, .group_error_indicator,
    .bus_fault_indicator, .supply_indicator, .maintenance_indicator,
    .cyc_out_data, .cyc_in_data);
`default_nettype wire

// ==== verif/testbench.sv ====
// Self-checking bench for the station diagnostic indicator
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import sdi_pkg::*;
    logic clk = 0, reset = 1, avs_read = 0, avs_write = 0, irq;
    logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hf;
    logic [31:0] avs_writedata = 32'h0, cyc_in_in = 32'h0, word = 32'h0, q;
    logic [31:0] avs_readdata, cyc_out_in, cyc_out_data, cyc_in_data;
    logic end_module_missing = 0, too_many_modules = 0, backplane_fault = 0;
    logic supply_ok = 1, hw_defect = 0, cfg_mismatch = 0, module_error = 0;
    logic diag_pending = 0, fw_update = 0, maintenance_indicator_request = 0;
    logic module_event = 0, record_req = 0, avs_waitrequest, maintenance_indicator_alarm;
    logic [4:0] fail_slot = 5'h1;
    logic [2:0] cmd = 3'h0;
    logic master_fail_event, no_controller, connect_frame_bad, record_ack;
    logic data_exchange, group_error_indicator, bus_fault_indicator;
    logic supply_indicator, maintenance_indicator;
    int mismatches = 0, num_checks = 0;
    logic [31:0] rs = 32'hc817;
    always #2 clk = ~clk;
    sdi_master_model far (.clk, .reset, .cmd, .word, .master_fail_event,
        .no_controller, .connect_frame_bad, .cyc_out_in);
    sdi_station dut (.clk, .reset, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
        .end_module_missing, .too_many_modules, .backplane_fault, .fail_slot,
        .master_fail_event, .supply_ok, .hw_defect, .connect_frame_bad,
        .no_controller, .cfg_mismatch, .module_error, .diag_pending,
        .fw_update, .maintenance_indicator_request, .cyc_out_in, .cyc_out_data, .cyc_in_in,
        .cyc_in_data, .data_exchange, .module_event, .record_req, .record_ack,
        .maintenance_indicator_alarm, .group_error_indicator, .bus_fault_indicator,
        .supply_indicator, .maintenance_indicator, .irq);
    function automatic logic [31:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction
    // Expected module status codes of slots 1..16
    function automatic logic [31:0] ms_exp(input int fs);
        logic [31:0] v;
        for (int i = 1; i <= 16; i++)
            v[2*i-2 +: 2] = (i < fs) ? MS_FAULT : MS_NO_MODULE;
        return v;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        avs_write <= 0;
        avs_read <= 0;
        chk(n < 50, 1);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        #(4 * 40000);
        mismatches++;
        conclude();
    end
    initial
    begin
        logic [31:0] r;
        int fs;
        logic [2:0] m;
        logic [4:0] c;
        repeat (8) @(posedge clk);
        reset <= 0;
        cyc(1);
        chk({data_exchange, irq, group_error_indicator, supply_indicator}, 0);
        bus(0, REG_CTRL, 0);
        chk(q, CTRL_RST);
        bus(0, REG_IRQ_MASK, 0);
        chk(q, MASK_RST);
        bus(1, 4'hf, 32'hffff_ffff);
        bus(0, 4'hf, 0);
        chk(q, UNMAPPED_DATA);
        $display("test registers done");
        for (int k = 0; k < 3; k++)
        begin
            r = rnd();
            fs = (k == 0) ? 1 : (k == 2) ? 17 : 1 + r % 17;
            fail_slot <= 5'(fs);
            module_event <= r[3];
            diag_pending <= (k == 1);
            {end_module_missing, too_many_modules, backplane_fault} <= 3'b100 >> k;
            cyc(4);
            chk(data_exchange, 0);
            bus(0, REG_SLOT_ID, 0);
            chk(q[16:0], 17'h1ffff);
            bus(0, REG_SLOT_MS, 0);
            chk(q, ms_exp(fs));
            bus(0, REG_IRQ_INFO, 0);
            chk(q[25:24], MS_NO_MODULE);
            chk(q[17:0], {(k == 1) ? SDI_IRQ_DIAG :
                r[3] ? SDI_IRQ_HW : SDI_IRQ_NONE, (k == 1) ?
                8'(DIAG_REC_LEN + 4) : r[3] ? 8'(HW_IRQ_LEN + 4) : 8'h0,
                PROC_PAD_BYTE});
            {end_module_missing, too_many_modules, backplane_fault} <= 3'h0;
            diag_pending <= 0;
            bus(1, REG_CTRL, 1);
            cyc(4);
            chk(data_exchange, 1);
        end
        $display("test faulty configuration done");
        r = rnd();
        word <= r;
        cyc_in_in <= ~r;
        cyc(4);
        chk(cyc_out_data, r);
        chk(cyc_in_data, {16'h0, ~r[15:0]});
        cmd <= 3'b100;
        cyc(4);
        chk(data_exchange, 0);
        word <= rnd();
        cyc_in_in <= rs;
        record_req <= 1;
        cyc(1);
        record_req <= 0;
        cyc(1);
        chk(record_ack, 1);
        cyc(2);
        chk(cyc_out_data, r);
        chk(cyc_in_data, {16'h0, ~r[15:0]});
        bus(0, REG_STATUS, 0);
        chk(q, 32'(SDI_FAILED));
        cmd <= 3'h0;
        bus(1, REG_CTRL, 1);
        cyc(4);
        chk(data_exchange, 1);
        $display("test slave failure done");
        for (int i = 0; i < 24; i++)
        begin
            r = rnd();
            c = r[4:0];
            fw_update <= c[4];
            supply_ok <= !c[3] | r[5];
            hw_defect <= c[3] & r[5];
            cmd <= {1'b0, c[2], c[1]};
            cfg_mismatch <= c[0] & r[6];
            module_error <= c[0] & r[7];
            diag_pending <= c[0] & !r[6] & !r[7];
            m[2] = !c[4] && !c[3] && (c[2] || c[1]) && !c[0];
            m[1] = !c[4] && !c[3] && !c[2] && c[1];
            m[0] = 0;
            cyc(4);
            chk({group_error_indicator, bus_fault_indicator, supply_indicator} & ~m,
                (c[4] ? 3'b110 : c[3] ? 3'b000 : {c[0], c[2], 1'b1}) & ~m);
        end
        {fw_update, hw_defect, cfg_mismatch, module_error, diag_pending} <= 5'h0;
        supply_ok <= 1;
        cmd <= 3'h0;
        $display("test indicators done");
        bus(1, REG_IRQ_MASK, 32'h1 << EV_MAINTENANCE_INDICATOR);
        maintenance_indicator_request <= 1;
        cyc(2);
        chk(maintenance_indicator_alarm, 1);
        cyc(1);
        chk(irq, 1);
        bus(0, REG_IRQ_STAT, 0);
        chk(q[EV_MAINTENANCE_INDICATOR], 1);
        bus(1, REG_IRQ_MASK, 0);
        cyc(1);
        chk(irq, 0);
        bus(1, REG_IRQ_MASK, 32'h1 << EV_MAINTENANCE_INDICATOR);
        bus(1, REG_IRQ_STAT, 32'h1 << EV_MAINTENANCE_INDICATOR);
        cyc(1);
        chk(irq, 0);
        chk(maintenance_indicator, 1);
        maintenance_indicator_request <= 0;
        $display("test interrupt done");
        conclude();
    end
endmodule
`default_nettype wire
